// ==== design/pdc_pkg.sv ====
// package for the diagnostic and control register group of the single-pair transceiver
// assumes one clock domain and a 16-bit register port addressed by register index
package pdc_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int          PDC_ADDR_W = 8;
    localparam int          PDC_DATA_W = 16;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0]  PDC_OFF_EVENT_STATUS = 8'h18;
    localparam logic [7:0]  PDC_OFF_EVENT_CLEAR  = 8'h19;
    localparam logic [7:0]  PDC_OFF_SELFTEST_ONE = 8'h1b;
    localparam logic [7:0]  PDC_OFF_SELFTEST_LEN = 8'h1c;
    localparam logic [7:0]  PDC_OFF_CABLE_CTRL   = 8'h1e;
    localparam logic [7:0]  PDC_OFF_RESET_CTRL   = 8'h1f;

    // ------------------------------------------------------------
    // event flags: index 0 power-on done, 1 no frame, 2 power-save signal
    // ------------------------------------------------------------
    localparam int          PDC_EVT_N = 3;
    localparam int          PDC_FLAG_POS [PDC_EVT_N] = '{12, 11, 8};
    localparam int          PDC_EN_POS   [PDC_EVT_N] = '{4, 3, 0};
    localparam logic [2:0]  PDC_EN_RST = 3'h1;

    // ------------------------------------------------------------
    // self-test fields
    // ------------------------------------------------------------
    localparam int          PDC_ERR_W      = 8;
    localparam int          PDC_ERR_LSB    = 8;
    localparam int          PDC_LOCK_BIT   = 15;
    localparam int          PDC_GAP_W      = 8;
    localparam int          PDC_GAP_LSB    = 0;
    localparam logic [7:0]  PDC_GAP_RST    = 8'h7d;
    localparam int          PDC_GAP_SHIFT  = 2;
    localparam int          PDC_LEN_W      = 11;
    localparam int          PDC_LEN_LSB    = 0;
    localparam logic [10:0] PDC_LEN_RST    = 11'h5ee;

    // ------------------------------------------------------------
    // cable reflectometry and reset control fields
    // ------------------------------------------------------------
    localparam int          PDC_CABLE_GO_BIT   = 15;
    localparam int          PDC_CABLE_DONE_BIT = 1;
    localparam int          PDC_CABLE_FAIL_BIT = 0;
    localparam int          PDC_HWRST_BIT      = 15;
    localparam int          PDC_SWRST_BIT      = 14;
    localparam int          PDC_STBY_BIT       = 7;
    localparam logic [15:0] PDC_RSTCTRL_KEEP   = 16'h3fff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic power_save;
        logic no_frame;
        logic por_done;
    } pdc_events_type;

    typedef struct packed {
        logic [PDC_GAP_W-1:0]               gap_quads;
        logic [PDC_GAP_W+PDC_GAP_SHIFT-1:0] gap_bytes;
        logic [PDC_LEN_W-1:0]               frame_bytes;
    } pdc_bist_cfg_type;

    typedef enum logic {
        PDC_CABLE_IDLE,
        PDC_CABLE_RUN
    } pdc_cable_state_type;

    function automatic logic pdc_hit(input logic [PDC_ADDR_W-1:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction : pdc_hit

endpackage : pdc_pkg

// ==== design/pdc_err_counter.sv ====
// errored-byte counter of the self-test checker with lock-and-clear snapshot
// assumes err_byte is a one-cycle pulse per errored byte, synchronous to clk
`timescale 1ns/10ps
module pdc_err_counter
    import pdc_pkg::*;
#(
    parameter int W = PDC_ERR_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         sync_clr,
    input  wire logic         err_byte,
    input  wire logic         lock,
    input  wire logic         wrap_mode,
    output logic [W-1:0]      held_count
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    wire  logic   at_max = &count_reg;

    // ------------------------------------------------------------
    // running count
    // ------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        if (lock) begin
            // an error in the lock cycle starts the new interval
            count_next = {{(W-1){1'b0}}, err_byte};
        end else if (err_byte && !(at_max && !wrap_mode)) begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (sync_clr) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_count <= '0;
        end else if (sync_clr) begin
            held_count <= '0;
        end else if (lock) begin
            held_count <= count_reg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_saturate_hold: assert property (
        (at_max && !wrap_mode && err_byte && !lock && !sync_clr) |=> (&count_reg))
        else $error("errored-byte counter left its maximum while saturating");
    a_lock_capture: assert property (
        (lock && !sync_clr) |=> (held_count == $past(count_reg) && count_reg == {{(W-1){1'b0}}, $past(err_byte)})
            ##1 ($past(lock || sync_clr) || $stable(held_count)))
        else $error("lock did not capture and clear the error count");

endmodule : pdc_err_counter

// ==== design/pdc_regs.sv ====
// diagnostic and control register group: event flags with interrupt, self-test settings,
// cable reflectometry start/done/fail, reset and standby controls
// assumes a 16-bit register port addressed by register index, read data one cycle later,
// and that the self-test and cable engines outside report by one-cycle pulses
`timescale 1ns/10ps
module pdc_regs
    import pdc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [PDC_ADDR_W-1:0] reg_addr,
    input  wire logic [PDC_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [PDC_DATA_W-1:0] reg_rdata,
    input  wire pdc_events_type        events,
    input  wire logic                  selftest_err_byte,
    input  wire logic                  selftest_err_mode,
    output pdc_bist_cfg_type           bist_cfg,
    output logic                       cable_test_go,
    output logic                       cable_test_active,
    input  wire logic                  cable_done_in,
    input  wire logic                  cable_fail_in,
    output logic                       device_reset,
    output logic                       circuit_restart,
    output logic                       standby,
    output logic                       irq
);

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    wire logic wr_status = reg_wr && pdc_hit(reg_addr, PDC_OFF_EVENT_STATUS);
    wire logic wr_clear  = reg_wr && pdc_hit(reg_addr, PDC_OFF_EVENT_CLEAR);
    wire logic wr_bist1  = reg_wr && pdc_hit(reg_addr, PDC_OFF_SELFTEST_ONE);
    wire logic wr_bist2  = reg_wr && pdc_hit(reg_addr, PDC_OFF_SELFTEST_LEN);
    wire logic wr_cable  = reg_wr && pdc_hit(reg_addr, PDC_OFF_CABLE_CTRL);
    wire logic wr_rstc   = reg_wr && pdc_hit(reg_addr, PDC_OFF_RESET_CTRL);
    wire logic rd_status = reg_rd && pdc_hit(reg_addr, PDC_OFF_EVENT_STATUS);

    logic [PDC_EVT_N-1:0]   flag_reg;
    logic [PDC_EVT_N-1:0]   en_reg;
    logic [PDC_EVT_N-1:0]   evt;
    logic [PDC_GAP_W-1:0]   gap_reg;
    logic [PDC_LEN_W-1:0]   len_reg;
    logic [PDC_ERR_W-1:0]   err_held;
    logic [PDC_DATA_W-1:0]  rstctrl_reg;
    logic                   soft_rst_reg;
    logic                   restart_reg;
    logic                   cable_go_reg;
    logic                   cable_done_reg;
    logic                   cable_fail_reg;
    pdc_cable_state_type    cable_state;
    logic [PDC_DATA_W-1:0]  read_next;

    assign evt = {events.power_save, events.no_frame, events.por_done};

    // ------------------------------------------------------------
    // device reset from software
    // ------------------------------------------------------------
    // one-cycle pulse, then every register below except reg_rdata falls back to its reset value,
    // as with the reset pin; the pulse also leaves the block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_rstc && reg_wdata[PDC_HWRST_BIT] && !soft_rst_reg;
        end
    end
    assign device_reset = soft_rst_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            restart_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= wr_rstc && reg_wdata[PDC_SWRST_BIT];
        end
    end
    assign circuit_restart = restart_reg;

    // bits 15 and 14 are never stored, so they read back as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rstctrl_reg <= '0;
        end else if (soft_rst_reg) begin
            rstctrl_reg <= '0;
        end else if (wr_rstc) begin
            rstctrl_reg <= reg_wdata & PDC_RSTCTRL_KEEP;
        end
    end
    assign standby = rstctrl_reg[PDC_STBY_BIT];

    // ------------------------------------------------------------
    // event flags and interrupt
    // ------------------------------------------------------------
    // set beats a status read and the clear register, so an event in the clearing cycle is not lost
    for (genvar g = 0; g < PDC_EVT_N; g++) begin : gen_flag
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                flag_reg[g] <= 1'b0;
            end else if (soft_rst_reg) begin
                flag_reg[g] <= 1'b0;
            end else if (evt[g]) begin
                flag_reg[g] <= 1'b1;
            end else if (rd_status || (wr_clear && reg_wdata[PDC_FLAG_POS[g]])) begin
                flag_reg[g] <= 1'b0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                en_reg[g] <= PDC_EN_RST[g];
            end else if (soft_rst_reg) begin
                en_reg[g] <= PDC_EN_RST[g];
            end else if (wr_status) begin
                en_reg[g] <= reg_wdata[PDC_EN_POS[g]];
            end
        end
    end

    assign irq = |(flag_reg & en_reg);

    // ------------------------------------------------------------
    // self-test settings and error counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_reg <= PDC_GAP_RST;
        end else if (soft_rst_reg) begin
            gap_reg <= PDC_GAP_RST;
        end else if (wr_bist1) begin
            gap_reg <= reg_wdata[PDC_GAP_LSB +: PDC_GAP_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            len_reg <= PDC_LEN_RST;
        end else if (soft_rst_reg) begin
            len_reg <= PDC_LEN_RST;
        end else if (wr_bist2) begin
            len_reg <= reg_wdata[PDC_LEN_LSB +: PDC_LEN_W];
        end
    end

    assign bist_cfg.gap_quads   = gap_reg;
    assign bist_cfg.gap_bytes   = {gap_reg, {PDC_GAP_SHIFT{1'b0}}};
    assign bist_cfg.frame_bytes = len_reg;

    pdc_err_counter #(
        .W          (PDC_ERR_W)
    ) u_err_counter (
        .clk        (clk),
        .rst        (rst),
        .sync_clr   (soft_rst_reg),
        .err_byte   (selftest_err_byte),
        .lock       (wr_bist1 && reg_wdata[PDC_LOCK_BIT]),
        .wrap_mode  (selftest_err_mode),
        .held_count (err_held)
    );

    // ------------------------------------------------------------
    // cable reflectometry sequencing
    // ------------------------------------------------------------
    // the start bit reads one for as long as the measurement runs; a second
    // start while running is ignored rather than restarting the engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cable_state    <= PDC_CABLE_IDLE;
            cable_go_reg   <= 1'b0;
            cable_done_reg <= 1'b0;
            cable_fail_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            cable_state    <= PDC_CABLE_IDLE;
            cable_go_reg   <= 1'b0;
            cable_done_reg <= 1'b0;
            cable_fail_reg <= 1'b0;
        end else begin
            cable_go_reg <= 1'b0;
            case (cable_state)
                PDC_CABLE_IDLE: begin
                    if (wr_cable && reg_wdata[PDC_CABLE_GO_BIT]) begin
                        cable_state    <= PDC_CABLE_RUN;
                        cable_go_reg   <= 1'b1;
                        cable_done_reg <= 1'b0;
                        cable_fail_reg <= 1'b0;
                    end
                end
                PDC_CABLE_RUN: begin
                    if (cable_done_in) begin
                        cable_state    <= PDC_CABLE_IDLE;
                        cable_done_reg <= 1'b1;
                        cable_fail_reg <= cable_fail_in;
                    end
                end
                default: begin
                    cable_state <= PDC_CABLE_IDLE;
                end
            endcase
        end
    end

    assign cable_test_go     = cable_go_reg;
    assign cable_test_active = (cable_state == PDC_CABLE_RUN);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        read_next = '0;
        case (reg_addr)
            PDC_OFF_EVENT_STATUS: begin
                for (int i = 0; i < PDC_EVT_N; i++) begin
                    read_next[PDC_FLAG_POS[i]] = flag_reg[i];
                    read_next[PDC_EN_POS[i]]   = en_reg[i];
                end
            end
            PDC_OFF_SELFTEST_ONE: begin
                read_next[PDC_ERR_LSB +: PDC_ERR_W] = err_held;
                read_next[PDC_GAP_LSB +: PDC_GAP_W] = gap_reg;
            end
            PDC_OFF_SELFTEST_LEN: begin
                read_next[PDC_LEN_LSB +: PDC_LEN_W] = len_reg;
            end
            PDC_OFF_CABLE_CTRL: begin
                read_next[PDC_CABLE_GO_BIT]   = cable_test_active;
                read_next[PDC_CABLE_DONE_BIT] = cable_done_reg;
                read_next[PDC_CABLE_FAIL_BIT] = cable_fail_reg;
            end
            PDC_OFF_RESET_CTRL: begin
                read_next = rstctrl_reg;
            end
            default: begin
                read_next = '0;
            end
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? read_next : '0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_por_flag_set: assert property (
        (events.por_done && !soft_rst_reg) |=> flag_reg[0])
        else $error("power-on-done flag not latched");
    a_noframe_flag_set: assert property (
        (events.no_frame && !soft_rst_reg) |=> flag_reg[1])
        else $error("no-frame flag not latched");
    a_psave_flag_set: assert property (
        (events.power_save && !soft_rst_reg) |=> flag_reg[2])
        else $error("power-save-signal flag not latched");
    a_read_clears: assert property (
        (rd_status && !evt[1] && !soft_rst_reg) |=> (!flag_reg[1] && reg_rdata[PDC_FLAG_POS[1]] == $past(flag_reg[1])))
        else $error("status read did not clear the idle flag or returned a wrong value");
    a_irq_gating: assert property (
        (flag_reg[0] && !en_reg[0] && !flag_reg[1] && !flag_reg[2]) |-> !irq)
        else $error("interrupt raised by a masked flag");
    a_enable_write: assert property (
        (wr_status && !soft_rst_reg) |=> (en_reg[1] == $past(reg_wdata[PDC_EN_POS[1]]) && en_reg[2] == $past(reg_wdata[PDC_EN_POS[2]])))
        else $error("enable bits not written");
    a_frame_len: assert property (
        (wr_bist2 && !soft_rst_reg) |=> (bist_cfg.frame_bytes == $past(reg_wdata[PDC_LEN_W-1:0])))
        else $error("packet length field not written");
    a_cable_start: assert property (
        (cable_state == PDC_CABLE_IDLE && wr_cable && reg_wdata[PDC_CABLE_GO_BIT] && !soft_rst_reg)
            |=> (cable_test_go && cable_test_active && !cable_done_reg) ##1 !cable_test_go)
        else $error("cable measurement start not issued as one pulse");
    a_cable_finish: assert property (
        (cable_test_active && cable_done_in && !soft_rst_reg)
            |=> (!cable_test_active && cable_done_reg && cable_fail_reg == $past(cable_fail_in)))
        else $error("cable measurement completion not reported");
    a_hw_reset: assert property (
        (wr_rstc && reg_wdata[PDC_HWRST_BIT] && !soft_rst_reg)
            |=> device_reset ##1 (!device_reset && !standby && en_reg == PDC_EN_RST && gap_reg == PDC_GAP_RST))
        else $error("software device reset did not restore reset values");
    a_sw_restart: assert property (
        (wr_rstc && reg_wdata[PDC_SWRST_BIT] && !reg_wdata[PDC_HWRST_BIT] && !soft_rst_reg)
            |=> (circuit_restart && $stable(en_reg) && $stable(len_reg))
            ##1 (!circuit_restart || $past(wr_rstc && reg_wdata[PDC_SWRST_BIT])))
        else $error("restart did not pulse once or disturbed registers");
    a_standby_ctrl: assert property (
        (wr_rstc && !reg_wdata[PDC_HWRST_BIT] && !soft_rst_reg) |=> (standby == $past(reg_wdata[PDC_STBY_BIT])))
        else $error("standby control not following the write");
    a_por_flag_hold: assert property (
        (flag_reg[0] && !rd_status && !(wr_clear && reg_wdata[PDC_FLAG_POS[0]]) && !soft_rst_reg) |=> flag_reg[0])
        else $error("power-on-done flag dropped without a clear");
    a_noframe_clear: assert property (
        (wr_clear && reg_wdata[PDC_FLAG_POS[1]] && !evt[1] && !soft_rst_reg) |=> !flag_reg[1])
        else $error("no-frame flag not cleared by the clear register");
    a_por_enable: assert property (
        (wr_status && !soft_rst_reg) |=> (en_reg[0] == $past(reg_wdata[PDC_EN_POS[0]])))
        else $error("power-on-done enable not written");
    a_err_readback: assert property (
        (reg_rd && reg_addr == PDC_OFF_SELFTEST_ONE) |=> (reg_rdata[PDC_ERR_LSB +: PDC_ERR_W] == $past(err_held)))
        else $error("error count snapshot not returned on read");
    a_gap_write: assert property (
        (wr_bist1 && !soft_rst_reg) |=> (bist_cfg.gap_quads == $past(reg_wdata[PDC_GAP_LSB +: PDC_GAP_W])))
        else $error("gap field not written");
    a_gap_scale: assert property (
        bist_cfg.gap_bytes == bist_cfg.gap_quads * (2 ** PDC_GAP_SHIFT))
        else $error("gap in bytes is not four times the field");
    a_cable_idle_done: assert property (
        (cable_state == PDC_CABLE_IDLE && cable_done_in && !wr_cable && !soft_rst_reg)
            |=> ($stable(cable_done_reg) && $stable(cable_fail_reg)))
        else $error("cable result changed by a completion while idle");
    a_dev_reset_pulse: assert property (
        device_reset |=> !device_reset)
        else $error("software device reset longer than one cycle");
    a_irq_enabled: assert property (
        (flag_reg[2] && en_reg[2]) |-> irq)
        else $error("enabled power-save-signal flag did not raise the interrupt");

endmodule : pdc_regs

// ==== bench/pdc_regs_test.sv ====
// self-checking bench for the diagnostic and control register group
// assumes pdc_pkg is compiled first and that pdc_regs carries its own assertions
`timescale 1ns/10ps
module pdc_regs_test;
    import pdc_pkg::*;
    logic                  clk;
    logic                  rst;
    logic [PDC_ADDR_W-1:0] reg_addr;
    logic [PDC_DATA_W-1:0] reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [PDC_DATA_W-1:0] reg_rdata;
    pdc_events_type        events;
    logic                  err_b;
    logic                  err_m;
    pdc_bist_cfg_type      bist_cfg;
    logic                  go;
    logic                  act;
    logic                  c_done;
    logic                  c_fail;
    logic                  dev_rst;
    logic                  restart;
    logic                  standby;
    logic                  irq;
    int                    err_total;
    int                    num_checks;
    int                    cyc;
    pdc_regs u_pdc_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events), .selftest_err_byte(err_b),
        .selftest_err_mode(err_m), .bist_cfg(bist_cfg), .cable_test_go(go), .cable_test_active(act),
        .cable_done_in(c_done), .cable_fail_in(c_fail), .device_reset(dev_rst), .circuit_restart(restart),
        .standby(standby), .irq(irq));
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic pulse(input logic [2:0] e);
        @(posedge clk) events <= e;
        @(posedge clk) events <= 3'h0;
        #1;
    endtask : pulse
    task automatic errs(input int n);
        @(posedge clk) err_b <= 1'b1;
        repeat (n) @(posedge clk);
        err_b <= 1'b0;
    endtask : errs
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals();
        rd(8'h18, 16'h0010);
        rd(8'h1b, 16'h007d);
        rd(8'h1c, 16'h05ee);
        rd(8'h1e, 16'h0000);
        rd(8'h1f, 16'h0000);
        rd(8'h05, 16'h0000);
        chk(irq, 1'b0);
    endtask : t_reset_vals
    task automatic t_events();
        pulse(3'h7);
        chk(irq, 1'b1);
        rd(8'h18, 16'h1910);
        rd(8'h18, 16'h0010);
        wr(8'h18, 16'h0009);
        pulse(3'h1);
        chk(irq, 1'b0);
        pulse(3'h2);
        chk(irq, 1'b1);
        wr(8'h19, 16'h0800);
        chk(irq, 1'b0);
        pulse(3'h4);
        chk(irq, 1'b1);
        rd(8'h18, 16'h1109);
    endtask : t_events
    task automatic t_errcount();
        errs(300);
        wr(8'h1b, 16'h807d);
        rd(8'h1b, 16'hff7d);
        @(posedge clk) err_m <= 1'b1;
        errs(260);
        wr(8'h1b, 16'h807d);
        errs(5);
        rd(8'h1b, 16'h047d);
        wr(8'h1b, 16'h0003);
        wr(8'h1c, 16'hffff);
        chk(bist_cfg, {8'h03, 10'h00c, 11'h7ff});
        rd(8'h1c, 16'h07ff);
    endtask : t_errcount
    task automatic t_cable();
        wr(8'h1e, 16'h8000);
        chk({go, act}, 2'h3);
        @(posedge clk) #1 chk(go, 1'b0);
        rd(8'h1e, 16'h8000);
        @(posedge clk) {c_done, c_fail} <= 2'h3;
        @(posedge clk) {c_done, c_fail} <= 2'h0;
        rd(8'h1e, 16'h0003);
        @(posedge clk) c_done <= 1'b1;
        @(posedge clk) c_done <= 1'b0;
        rd(8'h1e, 16'h0003);
        wr(8'h1e, 16'h8000);
        rd(8'h1e, 16'h8000);
    endtask : t_cable
    task automatic t_resetctl();
        wr(8'h1f, 16'h0080);
        chk(standby, 1'b1);
        wr(8'h1f, 16'h4080);
        chk({restart, standby}, 2'h3);
        rd(8'h1f, 16'h0080);
        wr(8'h1f, 16'h8080);
        chk(dev_rst, 1'b1);
        @(posedge clk) #1 chk(standby, 1'b0);
        rd(8'h1b, 16'h007d);
        rd(8'h18, 16'h0010);
        rd(8'h1e, 16'h0000);
    endtask : t_resetctl
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {rst, reg_addr, reg_wdata, reg_wr, reg_rd, events} = '0;
        {err_b, err_m, c_done, c_fail, err_total, num_checks} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_events();
        t_errcount();
        t_cable();
        t_resetctl();
        end_of_test();
    end
endmodule : pdc_regs_test
